// *** include/dspc_consts.vh ***
// Purpose: shared constants of the decoder status pin control block
// Assumes: 20 MHz system clock, word-wide register port
// Notes: register offsets are byte addresses, one 32-bit word each
`ifndef DSPC_CONSTS_VH
`define DSPC_CONSTS_VH

// register offsets
`define DSPC_ADDR_CTRL 4'h0
`define DSPC_ADDR_STAT 4'h4

// control register field positions
`define DSPC_CTL_LOCK 0
`define DSPC_CTL_PRESET 1
`define DSPC_CTL_FMT 2
`define DSPC_CTL_MODE_LO 3
`define DSPC_CTL_MODE_HI 5
`define DSPC_CTL_EASE 6
`define DSPC_CTL_STRICT 7
`define DSPC_CTL_TSEL_LO 8
`define DSPC_CTL_TSEL_HI 11

// control register reset value: lock 0, preset 1, format 0, mode 3
`define DSPC_CTRL_RESET 12'h01A

// block error classes from the decoder core
`define DSPC_BLK_CLEAN 2'h0
`define DSPC_BLK_FIXED 2'h1
`define DSPC_BLK_UNFIX 2'h2

// error count window and thresholds
`define DSPC_ERR_WINDOW 48
`define DSPC_ERR_T1 20
`define DSPC_ERR_T2 40

// sync pulse width and clock period
`define DSPC_SYNC_PULSE_NS 421000
`define DSPC_CLK_NS 50

`endif

// *** src/dspc_errcnt.v ***
// Purpose: counts errored blocks over each window of 48 blocks
// Assumes: blk_strobe is a one-cycle pulse per received block
// Notes: the class of the last complete window is held until the next
`timescale 1ns/10ps
`include "dspc_consts.vh"

module dspc_errcnt #(
  parameter WINDOW = `DSPC_ERR_WINDOW, // blocks per window
  parameter T1 = `DSPC_ERR_T1, // upper bound of the low class
  parameter T2 = `DSPC_ERR_T2 // upper bound of the middle class
) (
  input wire clk, // system clock
  input wire reset_n, // synchronous reset, active low
  input wire blk_strobe, // one block received
  input wire blk_err, // that block had errors before correction
  output reg [1:0] err_class_ff // count class of last window
);

  reg [5:0] blk_cnt_ff; // blocks seen in this window
  reg [5:0] err_cnt_ff; // errored blocks in this window
  wire [5:0] err_total; // count including the current block

  assign err_total = err_cnt_ff + {5'h0_0, blk_err};

  // maps an error count to the two-bit class
  function [1:0] err_class;
    input [5:0] cnt;
    begin
      if (cnt == 6'h0_0) begin
        err_class = 2'h0;
      end else if (cnt <= T1[5:0]) begin
        err_class = 2'h1;
      end else if (cnt <= T2[5:0]) begin
        err_class = 2'h2;
      end else begin
        err_class = 2'h3;
      end
    end
  endfunction

  // window counter; the class updates only at window end
  always @(posedge clk) begin
    if (!reset_n) begin
      blk_cnt_ff <= 6'h0_0;
      err_cnt_ff <= 6'h0_0;
      err_class_ff <= 2'h0;
    end else if (blk_strobe) begin
      if (blk_cnt_ff == WINDOW[5:0] - 6'h0_1) begin
        // last block of the window closes the count
        blk_cnt_ff <= 6'h0_0;
        err_cnt_ff <= 6'h0_0;
        err_class_ff <= err_class(err_total);
      end else begin
        blk_cnt_ff <= blk_cnt_ff + 6'h0_1;
        err_cnt_ff <= err_total;
      end
    end
  end

endmodule

// *** src/dspc_top.v ***
// Purpose: configuration and open-drain status pin logic of a radio data decoder
// Assumes: decoder core signals share CLK; bit clock, carrier reference and
//   test pins come from outside and are synchronised here
// Notes: open-drain pins drive low only, *_OE high means the pin is pulled low
// Operation
// - lock select fixes phase: preset 0 -> 90, 1 -> 0
// - unlocked: phase follows traffic subcarrier, preset after sync reset
// - paging format select enables offset word E detection
// - three-bit pin mode selects pin functions, others open
// - polarity bit makes status pins active high
// - data changes on clock pin rise, or fall inverted
// - mode 2 traffic id pin low when keying present
// - mode 3 error and correction pins encode block result
// - mode 4 shows errored block count class per 48
// - block error count pins ignore polarity bit
// - modes 0 to 2: sync pin low while synchronised
// - mode 3: sync pin 421 us pulse per block while synchronised
// - sync pin shows state of preceding block
// - presence pin low when radio data detected
// - test pins pick normal, standby or test mode
// - soft flag ease bit eases soft decisions
// - presence strictness bit tightens presence detection
`timescale 1ns/10ps
`include "dspc_consts.vh"

module dspc_top #(
  // sync pulse length in cycles, least time rounded up
  parameter PULSE_CYC = (`DSPC_SYNC_PULSE_NS + `DSPC_CLK_NS - 1) / `DSPC_CLK_NS
) (
  input wire CLK, // 20 MHz system clock
  input wire RESET_N, // synchronous reset, active low
  input wire [3:0] ADDR, // register byte address
  input wire [31:0] WDATA, // register write data
  input wire WR, // write strobe, one cycle
  input wire RD, // read strobe, one cycle
  output reg [31:0] RDATA, // read data, valid the cycle after RD
  input wire BIT_CLK, // recovered bit clock, async
  input wire BIT_DATA, // recovered bit data, async
  input wire SOFT_FLAG, // soft decision flag, async
  input wire CARRIER_REF, // carrier reference, async
  input wire BLOCK_START, // block boundary pulse from core
  input wire BLOCK_SYNC, // core synchronised for the finished block
  input wire [1:0] BLOCK_CLASS, // result of the finished block
  input wire BLOCK_RAW_ERR, // finished block had raw errors
  input wire KEYING_DET, // area keying signal detected
  input wire TRAFFIC_DET, // traffic subcarrier detected
  input wire DATA_PRESENT, // radio data signal detected
  input wire SYNC_RESET, // synchronisation reset pulse from core
  input wire TEST_PIN_A, // test pin a, async
  input wire TEST_PIN_B, // test pin b, async
  output reg PHASE_ZERO, // demod phase: 1 = 0 deg, 0 = 90 deg
  output reg PHASE_AUTO, // phase tracking enabled in core
  output reg E_WORD_EN, // detect offset word E
  output reg SOFT_EASE, // ease soft decision generation
  output reg PRESENCE_STRICT, // tighten presence detection
  output reg STANDBY, // oscillator stop request
  output reg TEST_MODE, // device test mode selected
  output reg [4:0] OUT_PIN_O, // out pins c..g output value
  output reg [4:0] OUT_PIN_OE, // out pins c..g pull low
  output reg SYNC_PIN_O, // sync state pin output value
  output reg SYNC_PIN_OE, // sync state pin pull low
  output reg PRES_PIN_O, // data presence pin output value
  output reg PRES_PIN_OE // data presence pin pull low
);

  // pin indices within OUT_PIN
  localparam PIN_C = 0;
  localparam PIN_D = 1;
  localparam PIN_E = 2;
  localparam PIN_F = 3;
  localparam PIN_G = 4;

  // software written control word and the copy applied at block start
  reg [11:0] ctrl_ff; // written control bits
  reg [7:0] applied_ff; // control bits in effect
  reg pending_ff; // a write awaits the next block
  // sized copy of the reset word, so the applied byte is sliced on purpose
  localparam [11:0] CTRL_RST = `DSPC_CTRL_RESET;

  // synchronisers for outside inputs, stage one read only by stage two
  reg [5:0] sync1_ff; // first stage
  reg [5:0] sync2_ff; // second stage
  reg bclk_d_ff; // delayed bit clock for edge detection

  // latched block state
  reg synced_prev_ff; // sync state of preceding block
  reg [1:0] blk_class_ff; // result of preceding block
  reg data_ff; // retimed data
  reg soft_ff; // retimed soft flag
  reg [13:0] pulse_cnt_ff; // sync pulse down counter

  wire [1:0] be_class; // error count class
  wire bclk_s; // synchronised bit clock
  wire bclk_rise; // bit clock rising edge
  wire [2:0] mode; // applied pin mode
  wire pol; // applied polarity bit

  // combinational pin levels and enables
  reg [4:0] lvl; // desired pin levels
  reg [4:0] en; // pins enabled in this mode
  reg sync_lvl; // sync pin level
  reg pres_lvl; // presence pin level

  assign bclk_s = sync2_ff[0];
  assign bclk_rise = bclk_s & ~bclk_d_ff;
  assign mode = applied_ff[`DSPC_CTL_MODE_HI:`DSPC_CTL_MODE_LO];
  assign pol = mode[2];

  // register writes; applied copy waits for a block boundary
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_ff <= `DSPC_CTRL_RESET;
      applied_ff <= CTRL_RST[7:0];
      pending_ff <= 1'b0;
    end else begin
      if (WR && ADDR == `DSPC_ADDR_CTRL) begin
        ctrl_ff <= WDATA[11:0];
      end
      if (BLOCK_START) begin
        // take the newest word, including one written this cycle
        applied_ff <= (WR && ADDR == `DSPC_ADDR_CTRL) ? WDATA[7:0] : ctrl_ff[7:0];
        pending_ff <= 1'b0;
      end else if (WR && ADDR == `DSPC_ADDR_CTRL) begin
        pending_ff <= 1'b1;
      end
    end
  end

  // read data in the cycle after the strobe, unmapped reads zero
  always @(posedge CLK) begin
    if (!RESET_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        `DSPC_ADDR_CTRL: begin
          RDATA <= {20'h0_0000, ctrl_ff};
        end
        `DSPC_ADDR_STAT: begin
          RDATA <= {16'h0000, pending_ff, be_class, TEST_MODE, STANDBY,
                    DATA_PRESENT, synced_prev_ff, PHASE_ZERO, applied_ff};
        end
        default: begin
          RDATA <= 32'h0000_0000;
        end
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // two-flop synchronisers for bit clock, data, soft flag, carrier, test pins
  always @(posedge CLK) begin
    if (!RESET_N) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      bclk_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {TEST_PIN_B, TEST_PIN_A, CARRIER_REF, SOFT_FLAG, BIT_DATA, BIT_CLK};
      sync2_ff <= sync1_ff;
      bclk_d_ff <= bclk_s;
    end
  end

  // data retimed on the bit clock rise; the pin clock is inverted with
  // the polarity bit, so this is a pin rise at 0 and a pin fall at 1
  always @(posedge CLK) begin
    if (!RESET_N) begin
      data_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else if (bclk_rise) begin
      data_ff <= sync2_ff[1];
      soft_ff <= sync2_ff[2];
    end
  end

  // block state latched at the boundary, so pins show the previous block
  always @(posedge CLK) begin
    if (!RESET_N) begin
      synced_prev_ff <= 1'b0;
      blk_class_ff <= `DSPC_BLK_CLEAN;
      pulse_cnt_ff <= 14'h0000;
    end else if (BLOCK_START) begin
      synced_prev_ff <= BLOCK_SYNC;
      blk_class_ff <= BLOCK_CLASS;
      // pulse only while synchronised
      pulse_cnt_ff <= BLOCK_SYNC ? PULSE_CYC[13:0] : 14'h0000;
    end else if (pulse_cnt_ff != 14'h0000) begin
      pulse_cnt_ff <= pulse_cnt_ff - 14'h0001;
    end
  end

  // demodulation phase: fixed by preset, or tracking the subcarrier
  always @(posedge CLK) begin
    if (!RESET_N) begin
      PHASE_ZERO <= 1'b1; // preset resets to 1
      PHASE_AUTO <= 1'b1;
    end else begin
      PHASE_AUTO <= ~applied_ff[`DSPC_CTL_LOCK];
      if (applied_ff[`DSPC_CTL_LOCK]) begin
        PHASE_ZERO <= applied_ff[`DSPC_CTL_PRESET];
      end else if (SYNC_RESET) begin
        // start phase after a sync reset comes from the preset
        PHASE_ZERO <= applied_ff[`DSPC_CTL_PRESET];
      end else if (BLOCK_START) begin
        // subcarrier tracking moves the phase only at a block boundary to avoid mid-bit slips
        PHASE_ZERO <= TRAFFIC_DET;
      end
    end
  end

  // core control outputs and test pin decode
  always @(posedge CLK) begin
    if (!RESET_N) begin
      E_WORD_EN <= 1'b0;
      SOFT_EASE <= 1'b0;
      PRESENCE_STRICT <= 1'b0;
      STANDBY <= 1'b0;
      TEST_MODE <= 1'b0;
    end else begin
      E_WORD_EN <= applied_ff[`DSPC_CTL_FMT];
      SOFT_EASE <= applied_ff[`DSPC_CTL_EASE];
      PRESENCE_STRICT <= applied_ff[`DSPC_CTL_STRICT];
      // pin a high is test mode whatever pin b says
      TEST_MODE <= sync2_ff[4];
      STANDBY <= ~sync2_ff[4] & sync2_ff[5];
    end
  end

  // pin function selection per mode
  always @* begin
    lvl = 5'h1_F;
    en = 5'h0_0;
    // recovered clock inverted under the polarity bit, data as is
    lvl[PIN_C] = bclk_s ^ pol;
    lvl[PIN_D] = data_ff;
    lvl[PIN_E] = soft_ff;
    case (mode[1:0])
      2'h0: begin
        if (pol) begin
          // block error count, polarity fixed
          en[PIN_F] = 1'b1;
          en[PIN_G] = 1'b1;
          lvl[PIN_F] = be_class[1];
          lvl[PIN_G] = be_class[0];
        end
      end
      2'h1: begin
        en = 5'h0_7;
      end
      2'h2: begin
        en = 5'h1_F;
        lvl[PIN_F] = sync2_ff[3] ^ pol;
        lvl[PIN_G] = ~KEYING_DET ^ pol;
      end
      2'h3: begin
        en = 5'h1_F;
        // error low only when uncorrectable, correction high only if clean
        lvl[PIN_F] = (blk_class_ff != `DSPC_BLK_UNFIX) ^ pol;
        lvl[PIN_G] = (blk_class_ff == `DSPC_BLK_CLEAN) ^ pol;
      end
      default: begin
        en = 5'h0_0;
      end
    endcase
    // sync pin: level modes or pulse in mode 3
    if (mode[1:0] == 2'h3) begin
      sync_lvl = (~synced_prev_ff | (pulse_cnt_ff != 14'h0000)) ^ pol;
    end else begin
      sync_lvl = ~synced_prev_ff ^ pol;
    end
    pres_lvl = ~DATA_PRESENT ^ pol;
  end

  // open-drain pin registers: enable pulls low, disabled pins float high
  always @(posedge CLK) begin
    if (!RESET_N) begin
      OUT_PIN_O <= 5'h0_0;
      OUT_PIN_OE <= 5'h0_0;
      SYNC_PIN_O <= 1'b0;
      SYNC_PIN_OE <= 1'b0;
      PRES_PIN_O <= 1'b0;
      PRES_PIN_OE <= 1'b0;
    end else begin
      OUT_PIN_O <= 5'h0_0;
      OUT_PIN_OE <= en & ~lvl;
      SYNC_PIN_O <= 1'b0;
      SYNC_PIN_OE <= ~sync_lvl;
      PRES_PIN_O <= 1'b0;
      PRES_PIN_OE <= ~pres_lvl;
    end
  end

  // errored block counter over fixed windows
  dspc_errcnt #(
    .WINDOW(`DSPC_ERR_WINDOW),
    .T1(`DSPC_ERR_T1),
    .T2(`DSPC_ERR_T2)
  ) u_errcnt (
    .clk(CLK),
    .reset_n(RESET_N),
    .blk_strobe(BLOCK_START),
    .blk_err(BLOCK_RAW_ERR),
    .err_class_ff(be_class)
  );

endmodule

// *** tb/dspc_props.sv ***
// Purpose: port checks of the status pin block
// Assumes: mode_m tracks the applied pin mode from control writes
// Notes: sync pulse kept above 10 cycles in sim
`timescale 1ns/10ps
module dspc_props (
  input wire CLK, // system clock
  input wire RESET_N, // reset, active low
  input wire [3:0] ADDR, // register address
  input wire [31:0] WDATA, // write data
  input wire WR, // write strobe
  input wire BIT_CLK, // link clock
  input wire BLOCK_START, // block boundary
  input wire BLOCK_SYNC, // block synchronised
  input wire [1:0] BLOCK_CLASS, // block result
  input wire DATA_PRESENT, // radio data seen
  input wire TEST_PIN_A, // test pin a
  input wire TEST_PIN_B, // test pin b
  input wire PHASE_AUTO, // phase tracking
  input wire E_WORD_EN, // offset word e on
  input wire STANDBY, // standby request
  input wire TEST_MODE, // test mode
  input wire [4:0] OUT_PIN_OE, // pins c..g pulled low
  input wire SYNC_PIN_OE, // sync pin pulled low
  input wire PRES_PIN_OE // presence pin pulled low
);
  logic [2:0] mode_m; // applied pin mode
  logic [2:0] pend_m; // written, not yet applied
  logic pend_v; // a write waits for a block start
  logic [1:0] age; // cycles since reset, saturating
  logic ctl_wr; // control write now
  logic quiet; // no mode change under way
  assign ctl_wr = WR && ADDR == 4'h0;
  assign quiet = !pend_v && !ctl_wr && age == 2'h3;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // mirror of mode application; same-cycle write wins like in the design
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_m <= 3'h3;
      pend_m <= 3'h3;
      pend_v <= 1'b0;
      age <= 2'h0;
    end else begin
      age <= (age == 2'h3) ? age : age + 2'h1;
      pend_m <= ctl_wr ? WDATA[5:3] : pend_m;
      pend_v <= ctl_wr ? !BLOCK_START : pend_v && !BLOCK_START;
      if (ctl_wr && BLOCK_START) mode_m <= WDATA[5:3];
      else if (BLOCK_START && pend_v) mode_m <= pend_m;
    end
  end
  property p_open;
    quiet && $past(mode_m) == mode_m && mode_m[1:0] == 2'h0 |->
      OUT_PIN_OE[2:0] == 3'h0 && (mode_m[2] || OUT_PIN_OE[4:3] == 2'h0);
  endproperty
  a_open: assert property (p_open) else $error("open pin pulled low");
  property p_err;
    quiet && mode_m == 3'h3 && BLOCK_START ##1 !BLOCK_START |->
      ##2 OUT_PIN_OE[4:3] == {$past(BLOCK_CLASS, 3) != 2'h0, $past(BLOCK_CLASS, 3) == 2'h2};
  endproperty
  a_err: assert property (p_err) else $error("error pins wrong");
  property p_pulse;
    quiet && mode_m == 3'h3 && BLOCK_START |-> ##2 (!SYNC_PIN_OE) [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("sync pin not high");
  property p_level;
    quiet && $past(mode_m) == mode_m && mode_m < 3'h3 && BLOCK_START |->
      ##2 SYNC_PIN_OE == $past(BLOCK_SYNC, 2);
  endproperty
  a_level: assert property (p_level) else $error("sync level wrong");
  property p_pres;
    quiet && $past(mode_m) == mode_m && $stable(DATA_PRESENT) &&
      $past(DATA_PRESENT, 2) == DATA_PRESENT |-> PRES_PIN_OE == (DATA_PRESENT ^ mode_m[2]);
  endproperty
  a_pres: assert property (p_pres) else $error("presence pin wrong");
  property p_clk;
    quiet && mode_m[1:0] != 2'h0 && $past(mode_m) == mode_m && $past(mode_m, 3) == mode_m &&
      $past(BIT_CLK, 3) == $past(BIT_CLK, 4) |-> OUT_PIN_OE[0] == ($past(BIT_CLK, 3) ~^ mode_m[2]);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin wrong");
  property p_defer;
    ctl_wr && !BLOCK_START && !$past(BLOCK_START) && age == 2'h3 ##1 !BLOCK_START |=>
      $stable(PHASE_AUTO) && $stable(E_WORD_EN);
  endproperty
  a_defer: assert property (p_defer) else $error("control applied early");
  property p_test;
    $stable({TEST_PIN_A, TEST_PIN_B}) [*4] |->
      STANDBY == (!TEST_PIN_A && TEST_PIN_B) && TEST_MODE == TEST_PIN_A;
  endproperty
  a_test: assert property (p_test) else $error("operating state wrong");
endmodule

// *** tb/dspc_host_model.sv ***
// Purpose: host side: sources bit clock and data, samples the pins
// Assumes: pins read through pull-ups, polarity bit clear
// Notes: clock stands low outside the frame
`timescale 1ns/10ps
module dspc_host_model (
  input wire run, // start one frame
  input wire pin_c, // clock pin level
  input wire pin_d, // data pin level
  output logic bit_clk, // link clock to the block
  output logic bit_data, // link data to the block
  output logic [7:0] rx, // bits sampled from the pins
  output logic done // frame finished
);
  localparam logic [7:0] TX = 8'h5C; // frame contents
  int n_rx = 0; // samples taken
  // 400 ns period; data set in the low phase, away from the rise
  initial begin
    bit_clk = 1'b0;
    bit_data = 1'b1;
    rx = 8'h00;
    done = 1'b0;
    wait (run);
    #10;
    for (int i = 0; i < 8; i++) begin
      bit_data = TX[i];
      #100 bit_clk = 1'b1;
      #200 bit_clk = 1'b0;
      #100;
    end
    bit_data = !TX[7]; // idle line does not keep the last bit
    #2000 done = 1'b1;
  end
  // data taken on the clock pin falling edge
  always @(negedge pin_c) begin
    if (run && n_rx < 8) begin
      rx = {pin_d, rx[7:1]};
      n_rx++;
    end
  end
endmodule

// *** tb/dspc_top_bench.sv ***
// Purpose: self-checking bench of the status pin block
// Assumes: 20 MHz clock, short sync pulse
// Notes: pin level is O when pulled, else high
`timescale 1ns/10ps
module dspc_top_bench;
  localparam int PULSE = 20; // short sync pulse
  logic CLK = 1'b0; // system clock
  logic RESET_N = 1'b0; // reset, active low
  logic WR = 1'b0, RD = 1'b0; // strobes
  logic [3:0] ADDR = 4'h0; // address
  logic [31:0] WDATA = 32'h0000_0000; // write data
  logic [1:0] BLOCK_CLASS = 2'h0; // block result
  logic BLOCK_START = 1'b0, BLOCK_SYNC = 1'b0, BLOCK_RAW_ERR = 1'b0; // block strobe
  logic KEYING_DET = 1'b0, TRAFFIC_DET = 1'b0, DATA_PRESENT = 1'b0; // detectors
  logic CARRIER_REF = 1'b0; // carrier reference into the sync chain
  logic SYNC_RESET = 1'b0, TEST_PIN_A = 1'b0, TEST_PIN_B = 1'b0, run = 1'b0; // misc
  logic BIT_CLK, BIT_DATA, done; // link from host
  logic [7:0] rx; // frame seen by host
  wire [31:0] RDATA; // read data
  wire [4:0] OUT_PIN_O, OUT_PIN_OE; // pins c..g
  wire PHASE_ZERO, PHASE_AUTO, E_WORD_EN, SOFT_EASE, PRESENCE_STRICT, STANDBY, TEST_MODE;
  wire SYNC_PIN_O, SYNC_PIN_OE, PRES_PIN_O, PRES_PIN_OE; // status pins
  int n_errors = 0; // mismatches
  int n_tests = 0; // comparisons
  logic [31:0] v; // last read
  int cnt [6] = '{0, 20, 21, 40, 41, 48}; // errored blocks per window
  always #25 CLK = ~CLK;
  dspc_top #(.PULSE_CYC(PULSE)) dut (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .BIT_CLK,
    .BIT_DATA, .SOFT_FLAG(1'b0), .CARRIER_REF, .BLOCK_START, .BLOCK_SYNC, .BLOCK_CLASS,
    .BLOCK_RAW_ERR, .KEYING_DET, .TRAFFIC_DET, .DATA_PRESENT, .SYNC_RESET, .TEST_PIN_A,
    .TEST_PIN_B, .PHASE_ZERO, .PHASE_AUTO, .E_WORD_EN, .SOFT_EASE, .PRESENCE_STRICT, .STANDBY,
    .TEST_MODE, .OUT_PIN_O, .OUT_PIN_OE, .SYNC_PIN_O, .SYNC_PIN_OE, .PRES_PIN_O, .PRES_PIN_OE);
  dspc_host_model host (.run, .pin_c(OUT_PIN_OE[0] ? OUT_PIN_O[0] : 1'b1),
    .pin_d(OUT_PIN_OE[1] ? OUT_PIN_O[1] : 1'b1), .bit_clk(BIT_CLK), .bit_data(BIT_DATA), .rx, .done);
  task automatic results;
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // one block, then a gap longer than the sync pulse
  task automatic blk(input logic s, input logic [1:0] c, input logic e);
    @(posedge CLK);
    BLOCK_START <= 1'b1;
    BLOCK_SYNC <= s;
    BLOCK_CLASS <= c;
    BLOCK_RAW_ERR <= e;
    @(posedge CLK);
    BLOCK_START <= 1'b0;
    repeat (PULSE + 4) @(posedge CLK);
  endtask
  function automatic logic [1:0] cls(input int n);
    return n == 0 ? 2'h0 : n <= 20 ? 2'h1 : n <= 40 ? 2'h2 : 2'h3;
  endfunction
  initial begin
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(4'h0, v);
    chk(v, 32'h0000_001A);
    rd(4'h4, v);
    chk(v, 32'h0000_011A);
    rd(4'h8, v);
    chk(v, 32'h0000_0000);
    chk(32'({PHASE_AUTO, PHASE_ZERO, E_WORD_EN, SOFT_EASE, PRESENCE_STRICT}), 32'h18);
    run <= 1'b1;
    for (int i = 0; i < 400 && !done; i++) @(posedge CLK);
    chk(32'(rx), 32'h0000_005C);
    for (int i = 0; i < 2; i++) begin
      TRAFFIC_DET <= i[0]; // preset matches the known subcarrier
      wr(4'h0, 32'h0000_00DD | (i << 1)); // test select kept zero
      rd(4'h4, v);
      chk(32'({PHASE_AUTO, v[15]}), 32'({i == 0, 1'b1}));
      blk(1'b1, 2'h0, 1'b0);
      chk(32'({PHASE_AUTO, PHASE_ZERO, E_WORD_EN, SOFT_EASE, PRESENCE_STRICT}), 7 | (i << 3));
    end
    TRAFFIC_DET <= 1'b0;
    wr(4'h0, 32'h0000_001A);
    repeat (2) blk(1'b1, 2'h0, 1'b0);
    chk(32'(PHASE_ZERO), 32'h0);
    @(posedge CLK);
    SYNC_RESET <= 1'b1;
    @(posedge CLK);
    SYNC_RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    #1 chk(32'(PHASE_ZERO), 32'h1);
    for (int c = 0; c < 3; c++) begin
      blk(1'b1, 2'(c), 1'b0);
      chk(32'({SYNC_PIN_OE, OUT_PIN_OE[4:3]}), 32'({1'b1, c != 0, c == 2}));
    end
    blk(1'b0, 2'h0, 1'b0);
    chk(32'(SYNC_PIN_OE), 32'h0);
    wr(4'h0, 32'h0000_0012);
    for (int k = 0; k < 2; k++) begin
      KEYING_DET <= k[0];
      CARRIER_REF <= k[0];
      DATA_PRESENT <= k[0];
      blk(k[0], 2'h0, 1'b0);
      chk(32'({OUT_PIN_OE[4:3], SYNC_PIN_OE, PRES_PIN_OE}), 4 + k * 7);
    end
    wr(4'h0, 32'h0000_003A);
    blk(1'b1, 2'h0, 1'b0);
    chk(32'({SYNC_PIN_OE, PRES_PIN_OE}), 32'h0);
    wr(4'h0, 32'h0000_0002);
    blk(1'b1, 2'h2, 1'b0);
    chk(32'({OUT_PIN_O, SYNC_PIN_O, PRES_PIN_O, OUT_PIN_OE, SYNC_PIN_OE}), 32'h1);
    TEST_PIN_B <= 1'b1;
    repeat (6) @(posedge CLK);
    chk(32'({STANDBY, TEST_MODE}), 32'h2);
    TEST_PIN_A <= 1'b1;
    repeat (6) @(posedge CLK);
    chk(32'({STANDBY, TEST_MODE}), 32'h1);
    TEST_PIN_A <= 1'b0;
    TEST_PIN_B <= 1'b0;
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    wr(4'h0, 32'h0000_0022);
    foreach (cnt[j]) begin
      for (int b = 0; b < 48; b++) blk(1'b0, 2'h0, b < cnt[j]);
      chk(32'({OUT_PIN_OE[3], OUT_PIN_OE[4]}), 32'(cls(cnt[j]) ^ 2'h3));
    end
    results();
  end
  // cut a hang well past the expected run
  initial begin
    #1_000_000;
    n_errors++;
    results();
  end
endmodule
bind dspc_top dspc_props props (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .BIT_CLK, .BLOCK_START,
  .BLOCK_SYNC, .BLOCK_CLASS, .DATA_PRESENT, .TEST_PIN_A, .TEST_PIN_B, .PHASE_AUTO, .E_WORD_EN,
  .STANDBY, .TEST_MODE, .OUT_PIN_OE, .SYNC_PIN_OE, .PRES_PIN_OE);
